//--- dv/link_station_model.sv
// Link-side station model that hands link events to the reporter.
`timescale 1ns/1ps
module link_station_model
  import resp_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     ev_ready,
  output logic          ev_valid,
  output link_event_type ev
);
  initial begin
    ev_valid = 1'b0;
    ev = '0;
  end

  // The event is held until accepted, then the payload is scrambled so nothing relies on stale values.
  task automatic send(input link_event_kind_type k, input logic [7:0] t, input logic [21:0] a,
                      input logic [13:0] c, input logic s);
    ev_valid <= 1'b1;
    ev <= link_event_type'({k, t, a, c, s});
    @(posedge clk iff ev_ready === 1'b1);
    ev_valid <= 1'b0;
    ev <= link_event_type'(~{k, t, a, c, s});
    @(posedge clk);
  endtask
endmodule

//--- dv/response_reporter_asserts.sv
// Concurrent checks on the response reporter ports.
`timescale 1ns/1ps
module reporter_checker
  import resp_pkg::*;
#(
  parameter int NTRIB = 4
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        ev_valid,
  input link_event_type   ev,
  input wire logic        ev_ready,
  input tx_buffer_type    enq,
  input wire logic        enq_ready,
  input wire logic        halt_valid,
  input wire logic [7:0]  halt_trib
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  logic [7:0] halt_exp;
  wire host_halt = avs_write && !avs_waitrequest && avs_address == OFF_CONTROL
                   && avs_writedata[CTRL_HALT_BIT] && avs_byteenable[1:0] == 2'h3;
  wire link_halt = ev_valid && ev_ready && (ev.kind == ev_start_in_run || ev.kind == ev_maint_in_return);
  wire posts = ev_valid && ev_ready
               && ev.kind inside {ev_rx_complete, ev_rx_unused, ev_tx_complete, ev_tx_unacked};

  // The host strobe wins over a link halt in the same cycle.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      halt_exp <= 8'h00;
    end else if (host_halt) begin
      halt_exp <= avs_writedata[15:8];
    end else if (link_halt) begin
      halt_exp <= ev.trib;
    end
  end

  wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("request not held off in its first cycle");
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request held off longer than one cycle");
  type_bits_a: assert property (
    avs_read && !avs_waitrequest && avs_address == OFF_TYPE |-> avs_readdata[31:3] == 29'h0)
    else $error("type register wider than three bits");
  halt_pulse_a: assert property (halt_valid |=> !halt_valid)
    else $error("halt pulse longer than one cycle");
  host_halt_a: assert property (
    host_halt |-> ##[1:2] (halt_valid && halt_trib == halt_exp))
    else $error("host halt not signalled for its tributary");
  event_halt_a: assert property (
    link_halt && !host_halt |-> ##[1:2] (halt_valid && halt_trib == halt_exp))
    else $error("link halt not signalled for its tributary");
  slot_busy_a: assert property (posts |=> !ev_ready)
    else $error("event accepted while a response is posted");
  enq_open_a: assert property (enq.trib >= NTRIB |-> enq_ready)
    else $error("buffer for unknown tributary refused");

  cover property (host_halt);
  cover property (link_halt);
  cover property (!enq_ready);
endmodule

bind response_reporter reporter_checker #(.NTRIB(NTRIB)) reporter_checker_i (
  .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .ev_valid(ev_valid), .ev(ev), .ev_ready(ev_ready), .enq(enq),
  .enq_ready(enq_ready), .halt_valid(halt_valid), .halt_trib(halt_trib));

//--- dv/testbench.sv
// Self-checking testbench of the response reporter.
`timescale 1ns/1ps
module testbench;
  import resp_pkg::*;
  logic           clk;
  logic           reset;
  logic [4:0]     avs_address;
  logic           avs_read;
  logic           avs_write;
  logic [31:0]    avs_writedata;
  logic [3:0]     avs_byteenable;
  logic [31:0]    avs_readdata;
  logic           avs_waitrequest;
  logic           ev_valid;
  link_event_type ev;
  logic           ev_ready;
  logic           enq_valid;
  tx_buffer_type  enq;
  logic           enq_ready;
  logic           halt_valid;
  logic [7:0]     halt_trib;
  int             failures;
  int             total_checks;

  response_reporter response_reporter_i (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ev_valid(ev_valid), .ev(ev), .ev_ready(ev_ready), .enq_valid(enq_valid), .enq(enq),
    .enq_ready(enq_ready), .halt_valid(halt_valid), .halt_trib(halt_trib));
  link_station_model link_station_model_i (.clk(clk), .ev_ready(ev_ready), .ev_valid(ev_valid), .ev(ev));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    @(posedge clk iff avs_waitrequest === 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // Polls for a posted response, compares its words, then frees the slot.
  task automatic expect_resp(input logic [31:0] e [5], input int words, input logic [1:0] cat);
    logic [4:0]  offs [5];
    logic [31:0] q;
    int          n;
    offs = '{OFF_TYPE, OFF_TAG, OFF_ADDR_LOW, OFF_COUNT_WORD, OFF_EXT_COUNT};
    q = 32'h0;
    n = 0;
    while (q[0] !== 1'b1 && n < 20) begin
      rd(OFF_STATUS, q);
      n++;
    end
    check("response valid", 32'h1, {31'h0, q[0]});
    check("category", {30'h0, cat}, {30'h0, q[3:2]});
    for (int i = 0; i < words; i++) begin
      rd(offs[i], q);
      check("response word", e[i], q);
    end
    wr(OFF_RELEASE, 32'h0);
  endtask

  task automatic errs(input link_event_kind_type k, input logic [7:0] t, input int n, input logic s);
    for (int i = 0; i < n; i++) begin
      link_station_model_i.send(k, t, 22'h0, 14'h0, s);
    end
  endtask

  task automatic put(input logic [7:0] t, input logic [21:0] a, input logic [13:0] c);
    enq_valid <= 1'b1;
    enq <= '{trib: t, addr: a, count: c};
    @(posedge clk iff enq_ready === 1'b1);
    enq_valid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic test_disposition;
    link_event_kind_type k [4];
    logic [2:0]          c [4];
    logic [21:0]         a;
    logic [13:0]         n;
    k = '{ev_rx_complete, ev_rx_unused, ev_tx_complete, ev_tx_unacked};
    c = '{DISP_RX_COMPLETE, DISP_RX_UNUSED, DISP_TX_COMPLETE, DISP_TX_UNACKED};
    a = 22'h3ABCDE;
    for (int i = 0; i < 4; i++) begin
      n = 14'h3FFF - 14'(i);
      link_station_model_i.send(k[i], 8'(i + 1), a, n, 1'b0);
      expect_resp('{32'(c[i]), 32'(i + 1), 32'(a[15:0]), 32'({a[17:16], n}), 32'h0}, 4, 2'h3);
    end
    wr(OFF_CONTROL, 32'h1);
    link_station_model_i.send(ev_tx_unacked, 8'h3, a, 14'h1234, 1'b0);
    expect_resp('{32'(DISP_TX_UNACKED), 32'h3, 32'(a[15:0]), 32'(a[21:16]), 32'h1234}, 5, 2'h3);
    wr(OFF_CONTROL, 32'h0);
    $display("test disposition done");
  endtask

  task automatic test_thresholds;
    logic [31:0] q;
    logic [31:0] e [5];
    wr(OFF_CONTROL, 32'h200);
    errs(ev_rx_error, 8'h2, 6, 1'b0);
    rd(OFF_STATUS, q);
    check("rx count", 32'h6, {29'h0, q[10:8]});
    check("early response", 32'h0, {31'h0, q[0]});
    errs(ev_rx_error, 8'h2, 1, 1'b0);
    expect_resp('{32'(CONTROL_RESPONSE), 32'h2, 32'h0, 32'(INFO_RX_THRESHOLD), 32'h0}, 4, 2'h2);
    rd(OFF_STATUS, q);
    check("rx count", 32'h0, {29'h0, q[10:8]});
    wr(OFF_CONTROL, 32'h101);
    e = '{32'(CONTROL_RESPONSE), 32'h1, 32'h0, 32'h0, 32'(INFO_TX_THRESHOLD)};
    errs(ev_tx_error, 8'h1, 7, 1'b0);
    expect_resp(e, 5, 2'h2);
    rd(OFF_STATUS, q);
    check("tx count", 32'h0, {29'h0, q[14:12]});
    errs(ev_tx_error, 8'h1, 7, 1'b1);
    expect_resp(e, 5, 2'h2);
    rd(OFF_STATUS, q);
    check("tx count", 32'h7, {29'h0, q[14:12]});
    errs(ev_tx_error, 8'h1, 1, 1'b1);
    expect_resp(e, 5, 2'h2);
    wr(OFF_CONTROL, 32'h0);
    $display("test thresholds done");
  endtask

  task automatic test_halt;
    logic [31:0] q;
    logic [21:0] a;
    put(8'h9, 22'h1, 14'h1);
    for (int i = 0; i < 4; i++) begin
      put(8'h1, 22'h3F0000 + 22'(i), 14'h10 + 14'(i));
    end
    enq_valid <= 1'b1;
    @(negedge clk);
    check("queue full", 32'h0, {31'h0, enq_ready});
    @(posedge clk);
    enq_valid <= 1'b0;
    wr(OFF_CONTROL, 32'h102);
    for (int i = 0; i < 4; i++) begin
      a = 22'h3F0000 + 22'(i);
      expect_resp('{32'(DISP_TX_NOT_SENT), 32'h1, 32'(a[15:0]), 32'({a[17:16], 14'h10 + 14'(i)}), 32'h0}, 4, 2'h3);
    end
    rd(OFF_STATUS, q);
    check("queue drained", 32'h0, {31'h0, q[0]});
    link_station_model_i.send(ev_start_in_run, 8'h2, 22'h0, 14'h0, 1'b0);
    link_station_model_i.send(ev_maint_in_return, 8'h3, 22'h0, 14'h0, 1'b0);
    check("halt tributary", 32'h3, {24'h0, halt_trib});
    $display("test halt done");
  endtask

  initial begin
    failures = 0;
    total_checks = 0;
    reset = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    enq_valid = 1'b0;
    enq = '0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    test_disposition();
    test_thresholds();
    test_halt();
    results();
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end
endmodule

//--- rtl/resp_pkg.sv
// Shared constants, encodings and carrier types of the response reporter.
// Notes on behaviour
// RL1: After seven unacknowledged sends of a message, post a transmit threshold control response.
// RL2: Past the transmit threshold keep retransmitting; only the host stops it.
// RL3: Keep a pending-transmit queue per tributary; on halt return each with code 111.
// RL4: Every buffer disposition response carries its tributary address in the tag byte.
// RL5: Normal mode: low address word, address bits 17:16 in count word bits 15:14.
// RL6: Extended mode: address bits 21:16 sit in count word low byte bits 5:0.
// RL7: Character count is unsigned in bits 13:0; extended mode uses extended count word.
// RL8: Halt a tributary on host halt, start while running, or maintenance while returning.
// RL9: Post control responses for errors on our own, without any host request.
// RL10: Control response: tag byte, low address, address in count bits 13:8, code low byte.
// RL11: Extended mode control response: address 21:16 in count word, code in extended byte.
// RL12: Each control information code belongs to one of four categories.
// RL13: Seven consecutive receive errors report code 002.
// RL14: Reporting the receive threshold clears the receive error counter.
// RL15: Seven consecutive transmit errors report code 004.
// RL16: Reporting transmit threshold clears the counter except in the two start states.
// RL17: Each response carries a three-bit type code in type byte bits 2:0.
// RL18: Disposition codes: 000, 011, 100, 110, 111 as listed.
// RL19: Host reads every response register before releasing the response slot; the testbench skips the extended count word in normal mode.
package resp_pkg;

  localparam logic [4:0] OFF_TYPE        = 5'h00;
  localparam logic [4:0] OFF_TAG         = 5'h04;
  localparam logic [4:0] OFF_ADDR_LOW    = 5'h08;
  localparam logic [4:0] OFF_COUNT_WORD  = 5'h0C;
  localparam logic [4:0] OFF_EXT_COUNT   = 5'h10;
  localparam logic [4:0] OFF_CONTROL     = 5'h14;
  localparam logic [4:0] OFF_STATUS      = 5'h18;
  localparam logic [4:0] OFF_RELEASE     = 5'h1C;

  localparam int CTRL_EXT_BIT   = 0;
  localparam int CTRL_HALT_BIT  = 1;
  localparam int CTRL_TRIB_LSB  = 8;

  localparam logic [2:0] ERR_THRESHOLD    = 3'h7;
  localparam logic [2:0] DISP_RX_COMPLETE = 3'h0;
  localparam logic [2:0] DISP_RX_UNUSED   = 3'h3;
  localparam logic [2:0] DISP_TX_COMPLETE = 3'h4;
  localparam logic [2:0] DISP_TX_UNACKED  = 3'h6;
  localparam logic [2:0] DISP_TX_NOT_SENT = 3'h7;
  localparam logic [2:0] CONTROL_RESPONSE = 3'h1;

  localparam logic [7:0] INFO_RX_THRESHOLD = 8'h02;
  localparam logic [7:0] INFO_TX_THRESHOLD = 8'h04;
  localparam logic [7:0] INFO_SELECT_THRESHOLD = 8'h06;
  localparam logic [7:0] INFO_FIRST_PROTOCOL   = 8'h08;
  localparam logic [7:0] INFO_LAST_PROTOCOL    = 8'h0E;
  localparam logic [7:0] INFO_POLL_DEAD        = 8'h12;

  typedef enum logic [1:0] {
    cat_system_event    = 2'h0,
    cat_protocol_event  = 2'h1,
    cat_network_error   = 2'h2,
    cat_procedural_error = 2'h3
  } info_category_type;

  typedef enum logic [2:0] {
    ev_rx_complete     = 3'h0,
    ev_rx_unused       = 3'h1,
    ev_tx_complete     = 3'h2,
    ev_tx_unacked      = 3'h3,
    ev_rx_error        = 3'h4,
    ev_tx_error        = 3'h5,
    ev_start_in_run    = 3'h6,
    ev_maint_in_return = 3'h7
  } link_event_kind_type;

  typedef struct packed {
    link_event_kind_type kind;
    logic [7:0]          trib;
    logic [21:0]         addr;
    logic [13:0]         count;
    logic                in_start_state;
  } link_event_type;

  typedef struct packed {
    logic [7:0]  trib;
    logic [21:0] addr;
    logic [13:0] count;
  } tx_buffer_type;

  typedef struct packed {
    logic [2:0]  type_code;
    logic [7:0]  tag;
    logic [15:0] addr_low;
    logic [15:0] count_word;
    logic [15:0] ext_word;
  } response_type;

  function automatic info_category_type info_category(input logic [7:0] code);
    if (code == INFO_RX_THRESHOLD || code == INFO_TX_THRESHOLD || code == INFO_SELECT_THRESHOLD) begin
      return cat_network_error;
    end else if (code >= INFO_FIRST_PROTOCOL && code <= INFO_LAST_PROTOCOL) begin
      return cat_protocol_event;
    end else if (code == INFO_POLL_DEAD) begin
      return cat_system_event;
    end
    return cat_procedural_error;
  endfunction

endpackage

//--- rtl/response_reporter.sv
// Response reporter: buffer returns, threshold control responses and per-tributary transmit queues.
`timescale 1ns/1ps
module response_reporter
  import resp_pkg::*;
#(
  parameter int NTRIB = 4,
  parameter int DEPTH = 4
) (
  input  wire logic           clk,
  input  wire logic           reset,
  input  wire logic [4:0]     avs_address,
  input  wire logic           avs_read,
  input  wire logic           avs_write,
  input  wire logic [31:0]    avs_writedata,
  input  wire logic [3:0]     avs_byteenable,
  output logic      [31:0]    avs_readdata,
  output logic                avs_waitrequest,
  input  wire logic           ev_valid,
  input  link_event_type      ev,
  output logic                ev_ready,
  input  wire logic           enq_valid,
  input  tx_buffer_type       enq,
  output logic                enq_ready,
  output logic                halt_valid,
  output logic      [7:0]     halt_trib
);

  localparam int TRIB_W = $clog2(NTRIB);
  localparam int PTR_W  = $clog2(DEPTH);

  if (NTRIB < 2 || NTRIB > 256 || (NTRIB & (NTRIB - 1)) != 0 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_param
    $error("NTRIB and DEPTH must be powers of two, NTRIB in 2..256, DEPTH at least 2.");
  end

  typedef enum logic [1:0] {bus_idle = 2'b01, bus_ack = 2'b10} bus_state_type;

  function automatic logic [TRIB_W-1:0] first_index(input logic [NTRIB-1:0] v);
    first_index = '0;
    for (int i = NTRIB - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_index = TRIB_W'(i);
      end
    end
  endfunction

  // Buffer disposition layout depends on the address mode.
  function automatic response_type make_disposition(input logic [2:0] code, input logic [7:0] trib,
                                                    input logic [21:0] addr, input logic [13:0] count,
                                                    input logic ext);
    response_type r;
    r.type_code = code;                                     // [RL17]
    r.tag       = trib;                                     // [RL4]
    r.addr_low  = addr[15:0];
    if (ext) begin
      r.count_word = {10'h000, addr[21:16]};                // [RL6]
      r.ext_word   = {2'h0, count};                         // [RL7]
    end else begin
      r.count_word = {addr[17:16], count};                  // [RL5] [RL7]
      r.ext_word   = 16'h0000;
    end
    return r;
  endfunction

  function automatic response_type make_control(input logic [7:0] code, input logic [7:0] trib,
                                                input logic [21:0] addr, input logic ext);
    response_type r;
    r.type_code = CONTROL_RESPONSE;                         // [RL17]
    r.tag       = trib;                                     // [RL10]
    r.addr_low  = addr[15:0];
    if (ext) begin
      r.count_word = {10'h000, addr[21:16]};                // [RL11]
      r.ext_word   = {8'h00, code};                         // [RL11]
    end else begin
      r.count_word = {2'h0, addr[21:16], code};             // [RL10]
      r.ext_word   = 16'h0000;
    end
    return r;
  endfunction

  bus_state_type       bus_state;
  logic                ext_mode;
  logic [7:0]          ctrl_trib;
  response_type        resp;
  logic                resp_valid;
  info_category_type   resp_category;
  logic [2:0]          rx_cnt [NTRIB];
  logic [2:0]          tx_cnt [NTRIB];
  logic [NTRIB-1:0]    rx_thr;
  logic [NTRIB-1:0]    tx_thr;
  logic [NTRIB-1:0]    halt_pend;
  tx_buffer_type       q_mem [NTRIB*DEPTH];
  logic [PTR_W-1:0]    q_wr [NTRIB];
  logic [PTR_W-1:0]    q_rd [NTRIB];
  logic [PTR_W:0]      q_cnt [NTRIB];

  wire logic               bus_req    = avs_read | avs_write;
  wire logic               bus_fire   = bus_req && bus_state == bus_ack;
  wire logic               wr_fire    = bus_fire && avs_write;
  wire logic               host_halt  = wr_fire && avs_address == OFF_CONTROL && avs_byteenable[1:0] == 2'b11 &&
                                        avs_writedata[CTRL_HALT_BIT];
  wire logic [7:0]         host_trib  = avs_writedata[CTRL_TRIB_LSB +: 8];
  wire logic               release_wr = wr_fire && avs_address == OFF_RELEASE;

  logic [NTRIB-1:0] nonempty;
  always_comb begin
    for (int i = 0; i < NTRIB; i++) begin
      nonempty[i] = q_cnt[i] != '0;
    end
  end

  wire logic               thr_any    = |rx_thr || |tx_thr;
  wire logic [NTRIB-1:0]   drain_vec  = halt_pend & nonempty;
  wire logic               post_rx    = !resp_valid && |rx_thr;
  wire logic               post_tx    = !resp_valid && !(|rx_thr) && |tx_thr;
  wire logic               post_drain = !resp_valid && !thr_any && |drain_vec;
  wire logic [TRIB_W-1:0]  rx_idx     = first_index(rx_thr);
  wire logic [TRIB_W-1:0]  tx_idx     = first_index(tx_thr);
  wire logic [TRIB_W-1:0]  drain_idx  = first_index(drain_vec);

  assign ev_ready = !resp_valid && !thr_any && !(|drain_vec);
  wire logic               ev_take    = ev_valid && ev_ready;
  wire logic               ev_ok      = (ev.trib >> TRIB_W) == 8'h00;
  wire logic [TRIB_W-1:0]  ev_idx     = ev.trib[TRIB_W-1:0];
  wire logic               ev_act     = ev_take && ev_ok;
  wire logic               ev_posts   = ev_take && (ev.kind == ev_rx_complete || ev.kind == ev_rx_unused ||
                                                    ev.kind == ev_tx_complete || ev.kind == ev_tx_unacked);

  wire logic               enq_ok     = (enq.trib >> TRIB_W) == 8'h00;
  wire logic [TRIB_W-1:0]  enq_idx    = enq.trib[TRIB_W-1:0];
  assign enq_ready = !enq_ok || q_cnt[enq_idx] != (PTR_W + 1)'(DEPTH);
  wire logic               push       = enq_valid && enq_ready && enq_ok;

  wire logic               pop_tx     = ev_act && ev.kind == ev_tx_complete && nonempty[ev_idx];
  wire logic               pop        = post_drain || pop_tx;
  wire logic [TRIB_W-1:0]  pop_idx    = post_drain ? drain_idx : ev_idx;
  wire tx_buffer_type      drain_head = q_mem[{drain_idx, q_rd[drain_idx]}];

  // Halt sources; the link side sees one halt pulse naming the host tributary when host and link halt in the same cycle.
  wire logic               ev_halt    = ev_act && (ev.kind == ev_start_in_run || ev.kind == ev_maint_in_return);
  logic [NTRIB-1:0] halt_set;
  always_comb begin
    halt_set = '0;
    if (host_halt && (host_trib >> TRIB_W) == 8'h00) begin
      halt_set[host_trib[TRIB_W-1:0]] = 1'b1;                // [RL8]
    end
    if (ev_halt) begin
      halt_set[ev_idx] = 1'b1;                               // [RL8]
    end
  end

  // Error counters: the new value after an error of the current event.
  wire logic [2:0] rx_next = rx_cnt[ev_idx] + 3'h1;
  wire logic [2:0] tx_next = (tx_cnt[ev_idx] == ERR_THRESHOLD) ? ERR_THRESHOLD : tx_cnt[ev_idx] + 3'h1;
  wire logic       rx_hit  = ev_act && ev.kind == ev_rx_error && rx_next == ERR_THRESHOLD;
  wire logic       tx_hit  = ev_act && ev.kind == ev_tx_error && tx_next == ERR_THRESHOLD;

  logic [NTRIB-1:0] rx_thr_set, tx_thr_set, rx_thr_clr, tx_thr_clr;
  always_comb begin
    rx_thr_set = '0;
    tx_thr_set = '0;
    rx_thr_clr = '0;
    tx_thr_clr = '0;
    rx_thr_set[ev_idx] = rx_hit;                             // [RL13]
    tx_thr_set[ev_idx] = tx_hit;                             // [RL1] [RL15]
    rx_thr_clr[rx_idx] = post_rx;
    tx_thr_clr[tx_idx] = post_tx;
  end

  // Next response, chosen by priority: thresholds, halt drain, then link events.
  logic [7:0]   post_code;
  logic [7:0]   post_trib;
  response_type next_resp;
  always_comb begin
    post_code = 8'h00;
    post_trib = 8'h00;
    next_resp = resp;
    if (post_rx) begin
      post_code = INFO_RX_THRESHOLD;
      post_trib = 8'(rx_idx);
      next_resp = make_control(INFO_RX_THRESHOLD, 8'(rx_idx), 22'h000000, ext_mode);       // [RL9] [RL13]
    end else if (post_tx) begin
      post_code = INFO_TX_THRESHOLD;
      post_trib = 8'(tx_idx);
      next_resp = make_control(INFO_TX_THRESHOLD, 8'(tx_idx), 22'h000000, ext_mode);       // [RL9] [RL1]
    end else if (post_drain) begin
      next_resp = make_disposition(DISP_TX_NOT_SENT, drain_head.trib, drain_head.addr,
                                   drain_head.count, ext_mode);                            // [RL3] [RL18]
    end else if (ev_posts) begin
      unique case (ev.kind)
        ev_rx_complete: next_resp = make_disposition(DISP_RX_COMPLETE, ev.trib, ev.addr, ev.count, ext_mode);
        ev_rx_unused:   next_resp = make_disposition(DISP_RX_UNUSED, ev.trib, ev.addr, ev.count, ext_mode);
        ev_tx_complete: next_resp = make_disposition(DISP_TX_COMPLETE, ev.trib, ev.addr, ev.count, ext_mode);
        default:        next_resp = make_disposition(DISP_TX_UNACKED, ev.trib, ev.addr, ev.count, ext_mode);
      endcase                                                                              // [RL18]
    end
  end
  wire logic post_any = post_rx || post_tx || post_drain || ev_posts;

  // Register read mux; count and extended words are read whole in bits 15:0, unmapped offsets read zero.
  logic [31:0] read_value;
  always_comb begin
    unique case (avs_address)
      OFF_TYPE:       read_value = {29'h0, resp.type_code};
      OFF_TAG:        read_value = {24'h0, resp.tag};
      OFF_ADDR_LOW:   read_value = {16'h0, resp.addr_low};
      OFF_COUNT_WORD: read_value = {16'h0, resp.count_word};
      OFF_EXT_COUNT:  read_value = {16'h0, resp.ext_word};
      OFF_CONTROL:    read_value = {16'h0, ctrl_trib, 7'h00, ext_mode};
      OFF_STATUS:     read_value = {17'h0, tx_cnt[ctrl_trib[TRIB_W-1:0]], 1'b0, rx_cnt[ctrl_trib[TRIB_W-1:0]],
                                    4'h0, resp_category, 1'b0, resp_valid};
      default:        read_value = 32'h0000_0000;
    endcase
  end

  assign avs_waitrequest = bus_req && bus_state != bus_ack;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus_state    <= bus_idle;
      avs_readdata <= 32'h0000_0000;
    end else begin
      unique case (bus_state)
        bus_idle: begin
          if (bus_req) begin
            bus_state    <= bus_ack;
            avs_readdata <= read_value;
          end
        end
        bus_ack: bus_state <= bus_idle;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_mode  <= 1'b0;
      ctrl_trib <= 8'h00;
    end else if (wr_fire && avs_address == OFF_CONTROL) begin
      if (avs_byteenable[0]) begin
        ext_mode <= avs_writedata[CTRL_EXT_BIT];
      end
      if (avs_byteenable[1]) begin
        ctrl_trib <= host_trib;
      end
    end
  end

  // The slot holds one response until the host releases it, so unread data is never overwritten.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      resp          <= '0;
      resp_valid    <= 1'b0;
      resp_category <= cat_system_event;
    end else if (post_any) begin
      resp          <= next_resp;
      resp_valid    <= 1'b1;
      resp_category <= info_category(post_code);                                           // [RL12]
    end else if (release_wr) begin
      resp_valid    <= 1'b0;                                                               // [RL19]
    end
  end

  // Threshold and halt flags: a set in the same cycle as a clear wins.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_thr    <= '0;
      tx_thr    <= '0;
      halt_pend <= '0;
    end else begin
      rx_thr    <= (rx_thr & ~rx_thr_clr) | rx_thr_set;
      tx_thr    <= (tx_thr & ~tx_thr_clr) | tx_thr_set;
      halt_pend <= (halt_pend & nonempty) | halt_set;                                      // [RL3]
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      halt_valid <= 1'b0;
      halt_trib  <= 8'h00;
    end else begin
      halt_valid <= |halt_set;
      if (|halt_set) begin
        halt_trib <= (host_halt && (host_trib >> TRIB_W) == 8'h00) ? host_trib : ev.trib;
      end
    end
  end

  // Threshold reports do not halt the tributary; retransmission goes on until the host halts it. [RL2]
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NTRIB; i++) begin
        rx_cnt[i] <= 3'h0;
        tx_cnt[i] <= 3'h0;
      end
    end else if (ev_act) begin
      unique case (ev.kind)
        ev_rx_error:    rx_cnt[ev_idx] <= rx_hit ? 3'h0 : rx_next;                          // [RL13] [RL14]
        ev_rx_complete: rx_cnt[ev_idx] <= 3'h0;
        ev_tx_error:    tx_cnt[ev_idx] <= (tx_hit && !ev.in_start_state) ? 3'h0 : tx_next;  // [RL15] [RL16]
        ev_tx_complete: tx_cnt[ev_idx] <= 3'h0;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      q_mem[{enq_idx, q_wr[enq_idx]}] <= enq;                                              // [RL3]
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NTRIB; i++) begin
        q_wr[i]  <= '0;
        q_rd[i]  <= '0;
        q_cnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NTRIB; i++) begin
        if (push && enq_idx == TRIB_W'(i)) begin
          q_wr[i] <= q_wr[i] + PTR_W'(1);
        end
        if (pop && pop_idx == TRIB_W'(i)) begin
          q_rd[i] <= q_rd[i] + PTR_W'(1);
        end
        if ((push && enq_idx == TRIB_W'(i)) && !(pop && pop_idx == TRIB_W'(i))) begin
          q_cnt[i] <= q_cnt[i] + (PTR_W + 1)'(1);
        end else if (!(push && enq_idx == TRIB_W'(i)) && (pop && pop_idx == TRIB_W'(i))) begin
          q_cnt[i] <= q_cnt[i] - (PTR_W + 1)'(1);
        end
      end
    end
  end

endmodule
